// ===== verilog/etc_timer.sv
// What this block does
// - 8-bit count, compare and comparator
// - tick from prescaler or pin edge; 0 stops
// - bottom is 0x00, maximum is 0xFF
// - top is maximum or compare by mode
// - each tick clears, increments or decrements
// - count readable and writable at any time
// - processor count write beats counting
// - overflow flag set per mode, raises request
// - match asserted whenever count equals compare
// - compare flag set on following tick
// - compare request needs flag, enable, global
// - compare flag cleared on service or one
// - compare buffered in PWM modes only
// - buffer copied only at top (maximum)
// - access hits buffer or active compare
// - force strobe acts like match outside PWM modes, no flag
// - count write blocks next tick's match
// - output action field takes effect immediately outside PWM modes, a cycle later in them
// - output state kept across mode changes
// - output from match, mode, action, extremes
// - mode 0 normal, wrap, overflow at zero
// - mode 2 clears on match, compare top
// - mode 3 fast PWM, bottom to maximum
// - action 0 leaves output alone
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "etc_defines.svh"
module etc_timer #(
    parameter int PRESCALE_BITS = 10 // prescaler width, divides up to 1024
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external count pin, asynchronous
    input wire logic external_count_pin,
    // processor interrupt side
    input wire logic global_int_enable,
    input wire logic overflow_int_ack,
    input wire logic compare_int_ack,
    output logic overflow_irq,
    output logic compare_irq,
    // waveform output and pin override
    output logic compare_output,
    output logic compare_override
);
    if (PRESCALE_BITS < 10) begin : g_chk
        $error("PRESCALE_BITS must be at least 10");
    end

    // registers
    logic [7:0] count_q; // count value
    logic [7:0] compare_q; // active compare value
    logic [7:0] compare_buf_q; // buffered compare value
    etc_pkg::etc_cs_t cs_q; // clock select field
    etc_pkg::etc_wgm_t wgm_q; // waveform mode field
    etc_pkg::etc_com_t com_q; // output action field
    logic ovf_flag_q, cmp_flag_q; // timer flag register
    logic ovf_ie_q, cmp_ie_q; // timer mask register
    logic oc_q; // internal compare output state
    logic block_q; // match blocked until next tick
    etc_pkg::etc_dir_t dir_q; // phase correct direction
    logic [PRESCALE_BITS-1:0] pre_q; // free running prescaler
    logic pin_s1_q, pin_s2_q, pin_s3_q; // pin synchroniser and history

    // bus state
    logic aw_ok_q, w_ok_q; // address and data held
    logic [7:0] awaddr_q; // held write address
    logic [31:0] wdata_q; // held write data
    logic wstrb0_q; // low lane enabled

    // decoded write strobes
    logic wr_go, wr_ctrl, wr_count, wr_compare, wr_flag, wr_mask, wr_mapped;
    logic force_strobe; // one-cycle force compare pulse
    etc_pkg::etc_com_t com_now; // action field as it stands this cycle
    logic [7:0] wr_byte; // byte written
    assign wr_go = aw_ok_q && w_ok_q && !s_axi_bvalid;
    assign wr_byte = wdata_q[7:0];
    assign wr_ctrl = wr_go && wstrb0_q && awaddr_q == `ETC_OFF_CTRL;
    assign wr_count = wr_go && wstrb0_q && awaddr_q == `ETC_OFF_COUNT;
    assign wr_compare = wr_go && wstrb0_q && awaddr_q == `ETC_OFF_COMPARE;
    assign wr_flag = wr_go && wstrb0_q && awaddr_q == `ETC_OFF_FLAG;
    assign wr_mask = wr_go && wstrb0_q && awaddr_q == `ETC_OFF_MASK;
    assign wr_mapped = awaddr_q == `ETC_OFF_CTRL || awaddr_q == `ETC_OFF_COUNT
        || awaddr_q == `ETC_OFF_COMPARE || awaddr_q == `ETC_OFF_FLAG || awaddr_q == `ETC_OFF_MASK;
    assign force_strobe = wr_ctrl && wr_byte[`ETC_FOC_BIT];
    // a force strobe acts with the action written beside it, not the stale one
    assign com_now = wr_ctrl ? wr_byte[`ETC_COM_LSB +: 2] : com_q;
    // mode decode
    logic pwm; // either pwm mode selected
    assign pwm = wgm_q == `ETC_WGM_FAST || wgm_q == `ETC_WGM_PHASE;

    // prescaler runs always; only the selected tap matters
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end
    // pin passes two flops before the edge detector looks at it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            {pin_s3_q, pin_s2_q, pin_s1_q} <= 3'h0;
        end else begin
            {pin_s3_q, pin_s2_q, pin_s1_q} <= {pin_s2_q, pin_s1_q, external_count_pin};
        end
    end
    // timer tick selection
    logic tick;
    always_comb begin
        unique case (cs_q)
            `ETC_CS_STOP: tick = 1'b0;
            `ETC_CS_DIV1: tick = 1'b1;
            `ETC_CS_DIV8: tick = &pre_q[2:0];
            `ETC_CS_DIV64: tick = &pre_q[5:0];
            `ETC_CS_DIV256: tick = &pre_q[7:0];
            `ETC_CS_DIV1024: tick = &pre_q[9:0];
            `ETC_CS_EXT_FALL: tick = pin_s3_q && !pin_s2_q;
            `ETC_CS_EXT_RISE: tick = !pin_s3_q && pin_s2_q;
        endcase
    end
    // comparator and extreme values
    logic match, at_max, at_bottom, cmp_ev;
    assign match = count_q == compare_q;
    assign at_max = count_q == `ETC_MAX;
    assign at_bottom = count_q == `ETC_BOTTOM;
    // a blocked match is invisible to flag and waveform alike
    assign cmp_ev = tick && match && !block_q;
    // counter; a processor write wins over any count
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= `ETC_RST_BYTE;
        end else if (wr_count) begin
            count_q <= wr_byte;
        end else if (tick) begin
            unique case (wgm_q)
                `ETC_WGM_CTC: count_q <= match ? `ETC_BOTTOM : count_q + 8'h01;
                `ETC_WGM_PHASE: count_q <= (dir_q == etc_pkg::ETC_DOWN && !at_bottom) || (at_max)
                    ? count_q - 8'h01 : count_q + 8'h01;
                `ETC_WGM_NORMAL, `ETC_WGM_FAST: count_q <= count_q + 8'h01;
            endcase
        end
    end
    // direction for dual slope: turn at maximum and bottom
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dir_q <= etc_pkg::ETC_UP;
        end else if (wgm_q != `ETC_WGM_PHASE) begin
            dir_q <= etc_pkg::ETC_UP;
        end else if (tick && !wr_count) begin
            if (at_max) begin
                dir_q <= etc_pkg::ETC_DOWN;
            end else if (at_bottom) begin
                dir_q <= etc_pkg::ETC_UP;
            end
        end
    end
    // blocking lasts until the next tick, even while stopped
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            block_q <= 1'b0;
        end else if (wr_count) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end
    // overflow point per mode
    logic ovf_ev;
    assign ovf_ev = tick && !wr_count && (wgm_q == `ETC_WGM_PHASE
        ? (at_bottom && dir_q == etc_pkg::ETC_DOWN) : at_max);
    // flags: hardware set wins over any clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ovf_flag_q <= 1'b0;
            cmp_flag_q <= 1'b0;
        end else begin
            if (ovf_ev) begin
                ovf_flag_q <= 1'b1;
            end else if (overflow_int_ack || (wr_flag && wr_byte[`ETC_OVF_BIT])) begin
                ovf_flag_q <= 1'b0;
            end
            if (cmp_ev) begin
                cmp_flag_q <= 1'b1;
            end else if (compare_int_ack || (wr_flag && wr_byte[`ETC_CMP_BIT])) begin
                cmp_flag_q <= 1'b0;
            end
        end
    end
    // requests need flag, mask and global enable
    assign overflow_irq = ovf_flag_q && ovf_ie_q && global_int_enable;
    assign compare_irq = cmp_flag_q && cmp_ie_q && global_int_enable;
    // control and mask registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cs_q <= '0;
            wgm_q <= '0;
            com_q <= '0;
            ovf_ie_q <= 1'b0;
            cmp_ie_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                cs_q <= wr_byte[`ETC_CS_LSB +: 3];
                wgm_q <= wr_byte[`ETC_WGM_LSB +: 2];
                com_q <= wr_byte[`ETC_COM_LSB +: 2];
            end
            if (wr_mask) begin
                ovf_ie_q <= wr_byte[`ETC_OVF_BIT];
                cmp_ie_q <= wr_byte[`ETC_CMP_BIT];
            end
        end
    end
    // compare: buffer copied at top in pwm, direct write otherwise
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            compare_q <= `ETC_RST_BYTE;
            compare_buf_q <= `ETC_RST_BYTE;
        end else begin
            if (wr_compare) begin
                compare_buf_q <= wr_byte;
            end
            if (wr_compare && !pwm) begin
                compare_q <= wr_byte;
            end else if (pwm && tick && at_max) begin
                compare_q <= compare_buf_q;
            end
        end
    end
    // waveform generator; the state survives mode changes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            oc_q <= 1'b0;
        end else if (!pwm) begin
            if ((cmp_ev || force_strobe) && com_now != `ETC_COM_NONE) begin
                oc_q <= com_now == `ETC_COM_TOGGLE ? !oc_q : com_now == `ETC_COM_SET;
            end
        end else if (com_q[1]) begin
            // com 2 non-inverting, com 3 inverting; com 1 reserved
            if (wgm_q == `ETC_WGM_FAST && tick && at_max && !wr_count) begin
                oc_q <= !com_q[0];
            end else if (cmp_ev) begin
                if (wgm_q == `ETC_WGM_FAST || dir_q == etc_pkg::ETC_UP) begin
                    oc_q <= com_q[0];
                end else begin
                    oc_q <= !com_q[0];
                end
            end
        end
    end
    assign compare_output = oc_q;
    assign compare_override = com_q != `ETC_COM_NONE;
    // axi write channels taken independently, answered once both are held
    assign s_axi_awready = !aw_ok_q && !s_axi_bvalid;
    assign s_axi_wready = !w_ok_q && !s_axi_bvalid;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ETC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_ok_q <= 1'b0;
                w_ok_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `ETC_RESP_OKAY : `ETC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read mux; compare reads the side software writes
    logic [7:0] rd_byte;
    logic rd_mapped;
    always_comb begin
        rd_mapped = 1'b1;
        rd_byte = 8'h00;
        unique case (s_axi_araddr)
            `ETC_OFF_CTRL: rd_byte = {1'b0, com_q, wgm_q, cs_q};
            `ETC_OFF_COUNT: rd_byte = count_q;
            `ETC_OFF_COMPARE: rd_byte = pwm ? compare_buf_q : compare_q;
            `ETC_OFF_FLAG: rd_byte = {6'h00, cmp_flag_q, ovf_flag_q};
            `ETC_OFF_MASK: rd_byte = {6'h00, cmp_ie_q, ovf_ie_q};
            default: rd_mapped = 1'b0;
        endcase
    end

    // read answered one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `ETC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_mapped ? `ETC_RESP_OKAY : `ETC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    stop_holds_a: assert property (@(posedge clock) disable iff (!rst_b)
        cs_q == `ETC_CS_STOP && !wr_count |=> $stable(count_q)) else $error("count moved while stopped");
    write_wins_a: assert property (@(posedge clock) disable iff (!rst_b)
        wr_count |=> count_q == $past(wr_byte)) else $error("count write lost");
    match_flag_a: assert property (@(posedge clock) disable iff (!rst_b)
        tick && match && !block_q |=> cmp_flag_q) else $error("compare flag not set");
    write_block_a: assert property (@(posedge clock) disable iff (!rst_b)
        wr_count ##1 (tick && match) |-> !cmp_ev) else $error("match not blocked");
    compare_irq_a: assert property (@(posedge clock) disable iff (!rst_b)
        cmp_ev && cmp_ie_q && !wr_mask |=> compare_irq == global_int_enable) else $error("compare request missing");
    normal_wrap_a: assert property (@(posedge clock) disable iff (!rst_b)
        wgm_q == `ETC_WGM_NORMAL && tick && at_max && !wr_count |=> at_bottom && ovf_flag_q)
        else $error("normal wrap wrong");
    ctc_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        wgm_q == `ETC_WGM_CTC && tick && match && !wr_count |=> at_bottom) else $error("no clear on match");
    pwm_buffer_a: assert property (@(posedge clock) disable iff (!rst_b)
        pwm && !(tick && at_max) |=> $stable(compare_q)) else $error("compare changed mid period");
    force_toggle_a: assert property (@(posedge clock) disable iff (!rst_b)
        force_strobe && !pwm && com_now == `ETC_COM_TOGGLE && !cmp_ev |=> oc_q != $past(oc_q)
        && cmp_flag_q == $past(cmp_flag_q)) else $error("force strobe wrong");
endmodule : etc_timer
`default_nettype wire

// ===== include/etc_defines.svh
`ifndef ETC_DEFINES_SVH
`define ETC_DEFINES_SVH
// register byte offsets
`define ETC_OFF_CTRL 8'h00
`define ETC_OFF_COUNT 8'h04
`define ETC_OFF_COMPARE 8'h08
`define ETC_OFF_FLAG 8'h0C
`define ETC_OFF_MASK 8'h10
// control register field positions
`define ETC_CS_LSB 0
`define ETC_WGM_LSB 3
`define ETC_COM_LSB 5
`define ETC_FOC_BIT 7
// flag and mask bit positions
`define ETC_OVF_BIT 0
`define ETC_CMP_BIT 1
// counter values
`define ETC_BOTTOM 8'h00
`define ETC_MAX 8'hFF
// reset values
`define ETC_RST_BYTE 8'h00
// clock select codes
`define ETC_CS_STOP 3'h0
`define ETC_CS_DIV1 3'h1
`define ETC_CS_DIV8 3'h2
`define ETC_CS_DIV64 3'h3
`define ETC_CS_DIV256 3'h4
`define ETC_CS_DIV1024 3'h5
`define ETC_CS_EXT_FALL 3'h6
`define ETC_CS_EXT_RISE 3'h7
// waveform modes
`define ETC_WGM_NORMAL 2'h0
`define ETC_WGM_PHASE 2'h1
`define ETC_WGM_CTC 2'h2
`define ETC_WGM_FAST 2'h3
// output actions
`define ETC_COM_NONE 2'h0
`define ETC_COM_TOGGLE 2'h1
`define ETC_COM_CLEAR 2'h2
`define ETC_COM_SET 2'h3
// bus responses
`define ETC_RESP_OKAY 2'h0
`define ETC_RESP_SLVERR 2'h2
`endif

// ===== include/etc_pkg.sv
package etc_pkg;
    // counting direction in phase correct mode
    typedef enum logic {ETC_UP, ETC_DOWN} etc_dir_t;
    typedef logic [2:0] etc_cs_t;
    typedef logic [1:0] etc_wgm_t;
    typedef logic [1:0] etc_com_t;
endpackage : etc_pkg

// ===== test/etc_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "etc_defines.svh"
// one compare: counts it, flags a mismatch at once
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got %0h exp %0h", $time, (g), (e)); end end
module etc_timer_bench;
    // clock and reset
    logic clock;
    logic rst_b;
    // bus master side
    logic [7:0] awaddr, araddr;
    logic awvalid, wvalid, arvalid, awready, wready, arready, bvalid, rvalid;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    // pin and interrupt side
    logic pin, gie, oack, cack, ovf_irq, cmp_irq, c_out, c_ovr;
    // bench state and model
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    int i;
    logic [31:0] v;
    logic [1:0] r, c;
    logic [7:0] x;
    logic m_out; // model of the compare output state

    etc_timer #(.PRESCALE_BITS(10)) dut (
        .clock(clock), .rst_b(rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .external_count_pin(pin), .global_int_enable(gie),
        .overflow_int_ack(oack), .compare_int_ack(cack),
        .overflow_irq(ovf_irq), .compare_irq(cmp_irq),
        .compare_output(c_out), .compare_override(c_ovr)
    );

    // free-running clock, 8 ns period
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // hang guard: the whole run needs well under this
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // verdict in one place
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // bus write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rs);
        bit aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock);
            if (awvalid && awready) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        // bready is held high, so the answer is taken where it is seen
        do @(posedge clock); while (bvalid !== 1'b1);
        rs = bresp;
    endtask : wr

    // full-word write, response not of interest
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] rs;
        wr(a, {24'h000000, d}, 4'hF, rs);
    endtask : w

    // bus read: data and response taken at the edge where rvalid is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
    endtask : rd

    // control byte from its fields
    function automatic logic [7:0] ctl(input logic [2:0] cs, input logic [1:0] wm, input logic [1:0] cm,
                                       input logic fo);
        return {fo, cm, wm, cs};
    endfunction : ctl

    // run the timer on the undivided clock for n cycles, then stop it
    task automatic run(input int n, input logic [1:0] wm);
        w(`ETC_OFF_CTRL, ctl(3'h1, wm, 2'h0, 1'b0));
        repeat (n) @(posedge clock);
        w(`ETC_OFF_CTRL, ctl(3'h0, wm, 2'h0, 1'b0));
    endtask : run

    // one pulse on the count pin, long enough for the synchroniser
    task automatic pulse();
        pin <= 1'b1;
        repeat (4) @(posedge clock);
        pin <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : pulse

    // main sequence
    initial begin
        rst_b = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, arvalid, pin, gie, oack, cack} = '0;
        void'($urandom(32'h9997));
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        // every register and the output state start at zero
        for (i = 0; i < 5; i++) begin
            rd(8'(4 * i), v, r);
            `CHK(v, 32'h00000000)
        end
        `CHK(c_out, 1'b0)
        // random count values with the timer stopped, held after writing
        for (i = 0; i < 4; i++) begin
            x = 8'($urandom());
            wr(`ETC_OFF_COUNT, {24'hFFFFFF, x}, 4'hF, r);
            repeat (6) @(posedge clock);
            rd(`ETC_OFF_COUNT, v, r);
            `CHK(v, {24'h000000, x})
        end
        // lane 0 not enabled: write dropped
        wr(`ETC_OFF_COUNT, 32'h00000077, 4'hE, r);
        rd(`ETC_OFF_COUNT, v, r);
        `CHK(v, {24'h000000, x})
        // unmapped place refuses both ways
        wr(8'h14, 32'h000000FF, 4'hF, r);
        `CHK(r, `ETC_RESP_SLVERR)
        rd(8'h14, v, r);
        `CHK({r, v}, {`ETC_RESP_SLVERR, 32'h00000000})
        // force strobe through every output action, twice round
        m_out = 1'b0;
        for (i = 0; i < 8; i++) begin
            c = 2'(i % 4);
            w(`ETC_OFF_CTRL, ctl(3'h0, `ETC_WGM_NORMAL, c, 1'b1));
            m_out = (c == `ETC_COM_TOGGLE) ? ~m_out : (c == `ETC_COM_CLEAR) ? 1'b0 :
                    (c == `ETC_COM_SET) ? 1'b1 : m_out;
            repeat (2) @(posedge clock);
            `CHK(c_out, m_out)
            `CHK(c_ovr, c != 2'h0)
        end
        rd(`ETC_OFF_CTRL, v, r);
        `CHK(v, 32'h00000060)
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v, 32'h00000000)
        rd(`ETC_OFF_COUNT, v, r);
        `CHK(v, {24'h000000, x})
        // output state survives mode changes
        w(`ETC_OFF_CTRL, ctl(3'h0, `ETC_WGM_FAST, 2'h0, 1'b0));
        `CHK(c_out, m_out)
        w(`ETC_OFF_CTRL, ctl(3'h0, `ETC_WGM_PHASE, 2'h0, 1'b0));
        `CHK(c_out, m_out)
        // count written equal to compare: first tick's match is swallowed
        w(`ETC_OFF_CTRL, ctl(3'h0, `ETC_WGM_NORMAL, 2'h0, 1'b0));
        w(`ETC_OFF_COMPARE, 8'h33);
        w(`ETC_OFF_COUNT, 8'h33);
        run(0, `ETC_WGM_NORMAL);
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v[`ETC_CMP_BIT], 1'b0)
        rd(`ETC_OFF_COUNT, v, r);
        `CHK(v[7:0] > 8'h33 && v[7:0] < 8'h40, 1'b1)
        // normal mode: wrap and match both flag and raise requests
        w(`ETC_OFF_COUNT, 8'hF0);
        w(`ETC_OFF_COMPARE, 8'hF8);
        w(`ETC_OFF_MASK, 8'h03);
        gie <= 1'b1;
        run(40, `ETC_WGM_NORMAL);
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v, 32'h00000003)
        `CHK(ovf_irq, 1'b1)
        `CHK(cmp_irq, 1'b1)
        gie <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK({ovf_irq, cmp_irq}, 2'b00)
        gie <= 1'b1;
        w(`ETC_OFF_MASK, 8'h01);
        `CHK({ovf_irq, cmp_irq}, 2'b10)
        // service clears the compare flag, then one-bits clear only their bit
        cack <= 1'b1;
        @(posedge clock);
        cack <= 1'b0;
        @(posedge clock);
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v, 32'h00000001)
        w(`ETC_OFF_FLAG, 8'h02);
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v, 32'h00000001)
        w(`ETC_OFF_FLAG, 8'h01);
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v, 32'h00000000)
        // clear on match: count stays at or below the compare value
        w(`ETC_OFF_CTRL, ctl(3'h0, `ETC_WGM_CTC, 2'h0, 1'b0));
        w(`ETC_OFF_COUNT, 8'h00);
        w(`ETC_OFF_COMPARE, 8'h10);
        run(100, `ETC_WGM_CTC);
        rd(`ETC_OFF_COUNT, v, r);
        `CHK(v <= 32'h00000010, 1'b1)
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v, 32'h00000002)
        // fast pwm: new compare waits in the buffer until the top
        w(`ETC_OFF_CTRL, ctl(3'h0, `ETC_WGM_FAST, 2'h0, 1'b0));
        w(`ETC_OFF_FLAG, 8'h03);
        w(`ETC_OFF_COUNT, 8'h60);
        w(`ETC_OFF_COMPARE, 8'h70);
        rd(`ETC_OFF_COMPARE, v, r);
        `CHK(v, 32'h00000070)
        run(60, `ETC_WGM_FAST);
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v, 32'h00000000)
        run(300, `ETC_WGM_FAST);
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v, 32'h00000003)
        // phase correct: overflow only after the way down to bottom
        w(`ETC_OFF_FLAG, 8'h03);
        w(`ETC_OFF_CTRL, ctl(3'h0, `ETC_WGM_PHASE, 2'h0, 1'b0));
        w(`ETC_OFF_COUNT, 8'h02);
        run(300, `ETC_WGM_PHASE);
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v[`ETC_OVF_BIT], 1'b0)
        run(300, `ETC_WGM_PHASE);
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v[`ETC_OVF_BIT], 1'b1)
        oack <= 1'b1;
        @(posedge clock);
        oack <= 1'b0;
        @(posedge clock);
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v[`ETC_OVF_BIT], 1'b0)
        // count pin, rising then falling edges
        w(`ETC_OFF_CTRL, ctl(3'h0, `ETC_WGM_NORMAL, 2'h0, 1'b0));
        w(`ETC_OFF_COUNT, 8'h00);
        w(`ETC_OFF_CTRL, ctl(`ETC_CS_EXT_RISE, `ETC_WGM_NORMAL, 2'h0, 1'b0));
        repeat (5) pulse();
        rd(`ETC_OFF_COUNT, v, r);
        `CHK(v, 32'h00000005)
        w(`ETC_OFF_CTRL, ctl(`ETC_CS_EXT_FALL, `ETC_WGM_NORMAL, 2'h0, 1'b0));
        repeat (3) pulse();
        w(`ETC_OFF_CTRL, ctl(`ETC_CS_STOP, `ETC_WGM_NORMAL, 2'h0, 1'b0));
        rd(`ETC_OFF_COUNT, v, r);
        `CHK(v, 32'h00000008)
        // write while counting each clock lands over the count
        w(`ETC_OFF_CTRL, ctl(3'h1, `ETC_WGM_NORMAL, 2'h0, 1'b0));
        w(`ETC_OFF_FLAG, 8'h03);
        w(`ETC_OFF_COMPARE, 8'h05);
        w(`ETC_OFF_COUNT, 8'h05);
        rd(`ETC_OFF_COUNT, v, r);
        `CHK(v >= 32'h00000005 && v < 32'h00000010, 1'b1)
        rd(`ETC_OFF_FLAG, v, r);
        `CHK(v[`ETC_CMP_BIT], 1'b0)
        report_and_stop();
    end
endmodule : etc_timer_bench
`default_nettype wire
